// file: reset_sequencer.sv
/*
 * bidirectional reset sequencer with AXI4-Lite registers.
 * assumes synchronous pin inputs, one 200 MHz clock and an open-drain
 * reset line resolved outside from reset_in_pin_oe.
 */
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module reset_sequencer (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // reset sources and end of init from the core
  input  wire logic        sw_reset_req,
  input  wire logic        wdt_reset_req,
  input  wire logic        end_of_init_instr,
  // pins
  input  wire logic        reset_in_pin_i,
  output logic             reset_in_pin_o,
  output logic             reset_in_pin_oe,
  output logic             reset_indication_out,
  input  wire logic [15:0] boot_config_port,
  // to the rest of the chip
  output logic             core_reset,
  output logic             bootloader_start,
  output logic             irq
);

  typedef enum logic {ST_RUN, ST_SEQ} seq_state_e;

  rst_pin_if pin ();

  seq_state_e                      state_r;
  logic [reset_seq_pkg::CNT_W-1:0] seq_cnt_r;
  logic        ext_en_r, mode_r, src_hw_r, init_done_r, pin_o_r, pin_oe_r;
  logic        indication_r, core_reset_r, loader_r, irq_r;
  logic [3:0]  flags_r;
  logic [15:0] boot_cfg_r;
  logic [reset_seq_pkg::IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_set;
  logic        aw_have_r, w_have_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [7:0]  waddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic        wstrb0_r;
  logic [1:0]  bresp_r, rresp_r;
  logic        any_req, seq_start, seq_end, commit, cfg_wr, cfg_refused;

  // ************************************************************
  // pin filter
  // ************************************************************
  assign pin.pin_level = reset_in_pin_i;
  assign pin.own_drive = pin_oe_r;

  rst_pin_filter u_filter (
    .aclk    (aclk),
    .aresetn (aresetn),
    .p       (pin.filter)
  );

  // ************************************************************
  // reset sequence
  // ************************************************************
  assign any_req   = pin.ext_reset | sw_reset_req | wdt_reset_req;
  assign seq_start = (state_r == ST_RUN) && any_req;
  // without extension a held external low keeps the sequence going
  assign seq_end   = (state_r == ST_SEQ)
                     && (seq_cnt_r == reset_seq_pkg::CNT_W'(reset_seq_pkg::SEQ_CYCLES - 1))
                     && (mode_r || !pin.ext_low);

  // sequence counter; once started it always runs its full length
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r   <= ST_RUN;
      seq_cnt_r <= '0;
    end else begin
      unique case (state_r)
        ST_RUN: begin
          seq_cnt_r <= '0;
          if (any_req) state_r <= ST_SEQ;
        end
        ST_SEQ: begin
          if (seq_end) state_r <= ST_RUN;
          else if (seq_cnt_r != reset_seq_pkg::CNT_W'(reset_seq_pkg::SEQ_CYCLES - 1))
            seq_cnt_r <= seq_cnt_r + 1'b1;
        end
      endcase
    end
  end

  // mode latched at start: the enable bit itself is cleared by the reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r       <= 1'b0;
      src_hw_r     <= 1'b0;
      core_reset_r <= 1'b0;
      pin_oe_r     <= 1'b0;
      pin_o_r      <= 1'b0;
    end else if (seq_start) begin
      mode_r       <= ext_en_r;
      src_hw_r     <= pin.ext_reset;
      core_reset_r <= 1'b1;
      pin_oe_r     <= ext_en_r;
    end else if (seq_end) begin
      core_reset_r <= 1'b0;
      pin_oe_r     <= 1'b0;
    end
  end

  // reset indication flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_r <= reset_seq_pkg::FLAG_HW_LONG;
    end else if (seq_start) begin
      if (ext_en_r)           flags_r <= reset_seq_pkg::FLAG_HW_LONG;
      else if (pin.ext_reset) flags_r <= reset_seq_pkg::FLAG_HW_SHORT;
      else if (sw_reset_req)  flags_r <= reset_seq_pkg::FLAG_SW;
      else                    flags_r <= reset_seq_pkg::FLAG_WDT;
    end else if (state_r == ST_SEQ && src_hw_r && !mode_r && pin.ext_low
                 && seq_cnt_r == reset_seq_pkg::CNT_W'(reset_seq_pkg::SEQ_CYCLES - 1)) begin
      // line still low when the nominal sequence runs out: a long reset
      flags_r <= reset_seq_pkg::FLAG_HW_LONG;
    end
  end

  // boot configuration taken at the end of a bidirectional or external-pin sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_cfg_r <= reset_seq_pkg::BOOT_RESET;
      loader_r   <= 1'b0;
    end else if (seq_start) begin
      loader_r   <= 1'b0;
    end else if (seq_end && (mode_r || src_hw_r)) begin
      boot_cfg_r <= boot_config_port;
      loader_r   <= !boot_config_port[reset_seq_pkg::BOOT_STRAP_BIT];
    end
  end

  // indication output stays low until end of init after the sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      indication_r <= 1'b0;
      init_done_r  <= 1'b0;
    end else if (seq_start || state_r == ST_SEQ) begin
      indication_r <= 1'b0;
      init_done_r  <= 1'b0;
    end else if (end_of_init_instr) begin
      indication_r <= 1'b1;
      init_done_r  <= 1'b1;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  assign commit      = aw_have_r && w_have_r && !bvalid_r;
  assign cfg_wr      = commit && (waddr_r == reset_seq_pkg::OFS_CFG) && wstrb0_r;
  assign cfg_refused = cfg_wr && init_done_r
                       && (wdata_r[reset_seq_pkg::CFG_EXT_EN_BIT] != ext_en_r);

  // enable bit: cleared by every reset, frozen after end of init
  always_ff @(posedge aclk) begin
    if (!aresetn || seq_start) begin
      ext_en_r <= 1'b0;
    end else if (cfg_wr && !init_done_r && state_r == ST_RUN) begin
      ext_en_r <= wdata_r[reset_seq_pkg::CFG_EXT_EN_BIT];
    end
  end

  // write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= reset_seq_pkg::RESP_OKAY;
      waddr_r   <= '0;
      wdata_r   <= '0;
      wstrb0_r  <= 1'b0;
    end else begin
      if (awvalid && awready_r) begin
        aw_have_r <= 1'b1;
        awready_r <= 1'b0;
        waddr_r   <= awaddr;
      end
      if (wvalid && wready_r) begin
        w_have_r <= 1'b1;
        wready_r <= 1'b0;
        wdata_r  <= wdata;
        wstrb0_r <= wstrb[0];
      end
      if (commit) begin
        bvalid_r <= 1'b1;
        case (waddr_r)
          reset_seq_pkg::OFS_CFG, reset_seq_pkg::OFS_IRQ_STAT,
          reset_seq_pkg::OFS_IRQ_MASK: bresp_r <= reset_seq_pkg::RESP_OKAY;
          default:                     bresp_r <= reset_seq_pkg::RESP_SLVERR;
        endcase
      end
      if (bvalid_r && bready) begin
        bvalid_r  <= 1'b0;
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // read channel: one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= reset_seq_pkg::RESP_OKAY;
    end else if (arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rresp_r   <= reset_seq_pkg::RESP_OKAY;
      case (araddr)
        reset_seq_pkg::OFS_CFG:      rdata_r <= {31'h0, ext_en_r};
        reset_seq_pkg::OFS_STATUS:   rdata_r <= {24'h0, loader_r, mode_r,
                                                 core_reset_r, init_done_r, flags_r};
        reset_seq_pkg::OFS_BOOT:     rdata_r <= {16'h0, boot_cfg_r};
        reset_seq_pkg::OFS_IRQ_STAT: rdata_r <= {29'h0, irq_stat_r};
        reset_seq_pkg::OFS_IRQ_MASK: rdata_r <= {29'h0, irq_mask_r};
        default: begin
          rdata_r <= '0;
          rresp_r <= reset_seq_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && rready) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // ************************************************************
  // interrupts: sticky, write one to clear, set wins
  // ************************************************************
  always_comb begin
    irq_set = '0;
    irq_set[reset_seq_pkg::IRQ_SEQ_DONE]    = seq_end;
    irq_set[reset_seq_pkg::IRQ_EXT_RESET]   = pin.ext_reset;
    irq_set[reset_seq_pkg::IRQ_CFG_REFUSED] = cfg_refused;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      irq_r      <= 1'b0;
    end else begin
      if (commit && wstrb0_r && waddr_r == reset_seq_pkg::OFS_IRQ_STAT)
        irq_stat_r <= (irq_stat_r & ~wdata_r[reset_seq_pkg::IRQ_W-1:0]) | irq_set;
      else
        irq_stat_r <= irq_stat_r | irq_set;
      if (commit && wstrb0_r && waddr_r == reset_seq_pkg::OFS_IRQ_MASK)
        irq_mask_r <= wdata_r[reset_seq_pkg::IRQ_W-1:0];
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign awready              = awready_r;
  assign wready               = wready_r;
  assign bvalid               = bvalid_r;
  assign bresp                = bresp_r;
  assign arready              = arready_r;
  assign rvalid               = rvalid_r;
  assign rdata                = rdata_r;
  assign rresp                = rresp_r;
  assign reset_in_pin_o       = pin_o_r;   // open drain: only ever drives low
  assign reset_in_pin_oe      = pin_oe_r;
  assign reset_indication_out = indication_r;
  assign core_reset           = core_reset_r;
  assign bootloader_start     = loader_r;
  assign irq                  = irq_r;

  // ************************************************************
  // checks
  // ************************************************************
  chk_cfg_lock: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_wr && init_done_r && !seq_start |=> ext_en_r == $past(ext_en_r))
    else $error("enable bit changed after end of init");
  chk_enable_cleared: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_start |=> !ext_en_r) else $error("enable bit survived a reset");
  chk_long_flags: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_start && ext_en_r |=> flags_r == reset_seq_pkg::FLAG_HW_LONG)
    else $error("bidirectional reset not reported as long");
  chk_boot_capture: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_end && mode_r |=> boot_cfg_r == $past(boot_config_port))
    else $error("boot config not captured");
  chk_loader_start: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_end && mode_r |=> loader_r == !$past(boot_config_port[reset_seq_pkg::BOOT_STRAP_BIT]))
    else $error("bootloader start wrong");
  chk_stretch_full: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(core_reset_r) |-> $past(seq_cnt_r) ==
      reset_seq_pkg::CNT_W'(reset_seq_pkg::SEQ_CYCLES - 1))
    else $error("reset sequence cut short");
  chk_pin_pull_seq: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_start && ext_en_r |=> (pin_oe_r && core_reset_r)[*8])
    else $error("reset pin not pulled during sequence");
  chk_indication_low: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(indication_r) |-> $past(end_of_init_instr) && !$past(core_reset_r))
    else $error("indication released without end of init");

endmodule

// file: reset_seq_pkg.sv
/*
 * constants shared by the reset sequencer and its pin filter:
 * register offsets, field positions, reset values and timing counts.
 * assumes a single 200 MHz clock and a 32-bit AXI4-Lite register bus.
 */
package reset_seq_pkg;

  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int CLK_PERIOD_PS  = 5000;
  localparam int RECOG_TIME_NS  = 100;   // least low time on the reset pin
  localparam int RECOG_EXTRA    = 2;     // plus two cpu clocks
  localparam int RECOG_CYCLES   = (RECOG_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS
                                  + RECOG_EXTRA;
  localparam int SEQ_CYCLES     = 64;    // length of the internal reset sequence
  localparam int MASK_DEPTH     = 2;     // synchroniser latency covered after own drive
  localparam int CNT_W          = 8;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] OFS_CFG      = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_BOOT     = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

  // ************************************************************
  // fields
  // ************************************************************
  localparam int CFG_EXT_EN_BIT   = 0;
  localparam int ST_INIT_DONE_BIT = 4;
  localparam int ST_IN_RESET_BIT  = 5;
  localparam int ST_BIDIR_BIT     = 6;
  localparam int ST_LOADER_BIT    = 7;
  localparam int BOOT_STRAP_BIT   = 4;   // boot_strap_select_pin within boot_config_port
  localparam int IRQ_W            = 3;
  localparam int IRQ_SEQ_DONE     = 0;
  localparam int IRQ_EXT_RESET    = 1;
  localparam int IRQ_CFG_REFUSED  = 2;

  // reset indication flags {wdt, sw, hw_short, hw_long}
  localparam logic [3:0] FLAG_HW_LONG  = 4'h1;
  localparam logic [3:0] FLAG_HW_SHORT = 4'h2;
  localparam logic [3:0] FLAG_SW       = 4'h4;
  localparam logic [3:0] FLAG_WDT      = 4'h8;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [15:0] BOOT_RESET  = 16'hFFFF;

endpackage

// file: rst_pin_if.sv
/*
 * carrier between the sequencer and its reset pin filter.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface rst_pin_if;
  logic pin_level;   // raw reset pin level, synchronous input
  logic own_drive;   // sequencer is pulling the pin low
  logic ext_reset;   // one-cycle pulse: external low recognised
  logic ext_low;     // level: recognised external low still present

  modport filter (input pin_level, input own_drive, output ext_reset, output ext_low);
  modport seq    (output pin_level, output own_drive, input ext_reset, input ext_low);
endinterface

// file: rst_pin_filter.sv
/*
 * reset pin synchroniser and recognition filter.
 * assumes the sequencer reports its own pull-down through the carrier.
 */
`timescale 1ns/1ps
module rst_pin_filter (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // link to sequencer
  rst_pin_if.filter p
);

  logic                        sync1_r;
  logic                        sync2_r;
  logic [reset_seq_pkg::MASK_DEPTH-1:0] mask_r;
  logic [reset_seq_pkg::CNT_W-1:0]      low_cnt_r;
  logic                        ext_reset_r;
  logic                        ext_low_r;
  logic                        masked;

  // ************************************************************
  // synchroniser: sync1 feeds only sync2
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
    end else begin
      sync1_r <= p.pin_level;
      sync2_r <= sync1_r;
    end
  end

  // own drive is masked until it has left the synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_r <= '0;
    end else begin
      mask_r <= {mask_r[reset_seq_pkg::MASK_DEPTH-2:0], p.own_drive};
    end
  end

  assign masked = p.own_drive | (|mask_r);

  // low time counter, saturates once the reset is recognised
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_cnt_r   <= '0;
      ext_reset_r <= 1'b0;
      ext_low_r   <= 1'b0;
    end else if (sync2_r || masked) begin
      low_cnt_r   <= '0;
      ext_reset_r <= 1'b0;
      ext_low_r   <= 1'b0;
    end else if (low_cnt_r == reset_seq_pkg::CNT_W'(reset_seq_pkg::RECOG_CYCLES - 1)) begin
      ext_reset_r <= !ext_low_r;
      ext_low_r   <= 1'b1;
    end else begin
      low_cnt_r   <= low_cnt_r + 1'b1;
      ext_reset_r <= 1'b0;
    end
  end

  assign p.ext_reset = ext_reset_r;
  assign p.ext_low   = ext_low_r;

  chk_own_drive_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
    p.own_drive |=> !ext_reset_r) else $error("own drive taken as reset");
  chk_recog_min_time: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(ext_reset_r) |->
      $past(low_cnt_r) == reset_seq_pkg::CNT_W'(reset_seq_pkg::RECOG_CYCLES - 1))
    else $error("reset recognised too early");

endmodule

// file: reset_supervisor_model.sv
/*
 * external reset supervisor that shares the reset line with the sequencer.
 * assumes one clock shared with the sequencer and a pull-up on the line.
 */
`timescale 1ns/1ps
module reset_supervisor_model (
  // clock
  input  wire logic       aclk,
  // command from the bench
  input  wire logic       go,
  input  wire logic [7:0] len,
  // shared reset line
  input  wire logic       dev_o,
  input  wire logic       dev_oe,
  output logic            line
);
  // ************************************************************
  // low pulse generator
  // ************************************************************
  localparam int MIN_LOW = reset_seq_pkg::RECOG_CYCLES + 4;
  logic [7:0] low_cnt_r = 8'h00;

  // never shorter than recognition; margin covers the synchroniser
  always_ff @(posedge aclk) begin
    if (go && low_cnt_r == 8'h00) begin
      low_cnt_r <= (len < MIN_LOW) ? MIN_LOW[7:0] : len;
    end else if (low_cnt_r != 8'h00) begin
      low_cnt_r <= low_cnt_r - 8'h01;
    end
  end

  // only ever pulls low, the pull-up gives the high level
  assign line = !((low_cnt_r != 8'h00) || (dev_oe && !dev_o));
endmodule

// file: tb_bidirectional_reset_control.sv
/*
 * self-checking bench for the reset sequencer and its register bus.
 * assumes the supervisor model resolves the open-drain reset line.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_bidirectional_reset_control;
  // ************************************************************
  // signals
  // ************************************************************
  logic        aclk = 1'b0, aresetn = 1'b0, go = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        sw_req = 1'b0, wdt_req = 1'b0, eoi = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, len = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d, rnd = 32'hD1BB;
  logic [3:0]  wstrb = 4'h0, exp_flag;
  logic [15:0] boot_port = 16'hFFFF, exp_boot;
  logic [1:0]  bresp, rresp, r;
  logic        awready, wready, bvalid, arready, rvalid, exp_ld;
  logic        pin_o, pin_oe, line, rst_ind, core_reset, boot_start, irq;
  int          error_cnt = 0, n_compared = 0, n;

  always #2.5 aclk = ~aclk;

  reset_sequencer uut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready),
    .sw_reset_req(sw_req), .wdt_reset_req(wdt_req), .end_of_init_instr(eoi),
    .reset_in_pin_i(line), .reset_in_pin_o(pin_o), .reset_in_pin_oe(pin_oe),
    .reset_indication_out(rst_ind), .boot_config_port(boot_port),
    .core_reset(core_reset), .bootloader_start(boot_start), .irq(irq)
  );

  reset_supervisor_model sup (
    .aclk(aclk), .go(go), .len(len), .dev_o(pin_o), .dev_oe(pin_oe), .line(line)
  );

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // flags expected after a short request from source s with enable e
  function automatic logic [3:0] exp_flags(input int e, input int s);
    if (e == 1) return reset_seq_pkg::FLAG_HW_LONG;
    if (s == 0) return reset_seq_pkg::FLAG_SW;
    if (s == 1) return reset_seq_pkg::FLAG_WDT;
    return reset_seq_pkg::FLAG_HW_SHORT;
  endfunction

  // outputs are registered, so values read just after an edge are the sampled ones
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    int k;
    k = 0;
    resp = 2'h3;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // no limit of its own: the watchdog ends a hang
    while (k != 99) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        k = 99;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    int k;
    k = 0;
    resp = 2'h3;
    v = 32'h0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (k != 99) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
        k = 99;
      end
    end
  endtask

  // one request from software (0), watchdog (1) or the external line (2)
  task automatic fire(input int src, input logic [7:0] l);
    @(posedge aclk);
    sw_req <= (src == 0);
    wdt_req <= (src == 1);
    go <= (src == 2);
    len <= l;
    @(posedge aclk);
    sw_req <= 1'b0;
    wdt_req <= 1'b0;
    go <= 1'b0;
  endtask

  // measures one sequence; a watchdog request in mid-sequence must be refused
  task automatic wait_seq(input logic exp_oe, output int cnt);
    int k;
    k = 0;
    cnt = 0;
    while (core_reset !== 1'b1 && k < 200) begin
      @(posedge aclk);
      k++;
    end
    while (core_reset === 1'b1 && cnt < 300) begin
      `CHK(pin_oe, exp_oe)
      `CHK(pin_o, 1'b0)
      `CHK(rst_ind, 1'b0)
      wdt_req <= (cnt == 10);
      @(posedge aclk);
      cnt++;
    end
    `CHK(pin_oe, 1'b0)
  endtask

  task complete_run;
    $display("comparisons %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    complete_run();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(reset_seq_pkg::OFS_CFG, d, r);
    `CHK(d[0], 1'b0)
    rd(reset_seq_pkg::OFS_STATUS, d, r);
    `CHK(d[3:0], reset_seq_pkg::FLAG_HW_LONG)
    `CHK(rst_ind, 1'b0)
    rd(8'h40, d, r);
    `CHK({r, d}, {reset_seq_pkg::RESP_SLVERR, 32'h0})
    wr(8'h40, 32'h1, r);
    `CHK(r, reset_seq_pkg::RESP_SLVERR)
    exp_boot = reset_seq_pkg::BOOT_RESET;
    exp_ld = 1'b0;
    // every source, with and without bidirectional mode, random boot port
    for (int e = 1; e >= 0; e--) begin
      for (int s = 0; s < 3; s++) begin
        rnd = lfsr(rnd);
        boot_port <= {rnd[15:5], s[0], rnd[3:0]};
        wr(reset_seq_pkg::OFS_CFG, {31'h0, e[0]}, r);
        rd(reset_seq_pkg::OFS_CFG, d, r);
        `CHK(d[0], e[0])
        fire(s, 8'(26 + rnd[19:16]));
        wait_seq(e[0], n);
        `CHK(n, reset_seq_pkg::SEQ_CYCLES)
        // a sequence that does not capture the port leaves the loader off
        if (e == 1 || s == 2) begin
          exp_boot = boot_port;
          exp_ld = !boot_port[reset_seq_pkg::BOOT_STRAP_BIT];
        end else begin
          exp_ld = 1'b0;
        end
        exp_flag = exp_flags(e, s);
        rd(reset_seq_pkg::OFS_STATUS, d, r);
        `CHK(d[3:0], exp_flag)
        `CHK({d[7], boot_start}, {exp_ld, exp_ld})
        `CHK(d[6], e[0])
        rd(reset_seq_pkg::OFS_BOOT, d, r);
        `CHK(d[15:0], exp_boot)
        rd(reset_seq_pkg::OFS_CFG, d, r);
        `CHK(d[0], 1'b0)
        repeat (40) @(posedge aclk);
        `CHK(core_reset, 1'b0)
      end
    end
    // without extension a low that outlasts the sequence stretches it
    fire(2, 8'h78);
    wait_seq(1'b0, n);
    `CHK(n > reset_seq_pkg::SEQ_CYCLES, 1'b1)
    rd(reset_seq_pkg::OFS_STATUS, d, r);
    `CHK(d[3:0], reset_seq_pkg::FLAG_HW_LONG)
    // interrupt: raise, mask, clear
    rd(reset_seq_pkg::OFS_IRQ_STAT, d, r);
    `CHK({d[2:0], irq}, 4'h6)
    wr(reset_seq_pkg::OFS_IRQ_MASK, 32'h1, r);
    repeat (3) @(posedge aclk);
    `CHK(irq, 1'b1)
    wr(reset_seq_pkg::OFS_IRQ_STAT, 32'h1, r);
    repeat (3) @(posedge aclk);
    `CHK(irq, 1'b0)
    // end of init releases the indication and locks the enable bit
    @(posedge aclk);
    eoi <= 1'b1;
    @(posedge aclk);
    eoi <= 1'b0;
    repeat (3) @(posedge aclk);
    `CHK(rst_ind, 1'b1)
    wr(reset_seq_pkg::OFS_CFG, 32'h1, r);
    `CHK(r, reset_seq_pkg::RESP_OKAY)
    rd(reset_seq_pkg::OFS_CFG, d, r);
    `CHK(d[0], 1'b0)
    rd(reset_seq_pkg::OFS_IRQ_STAT, d, r);
    `CHK(d[2:0], 3'h6)
    complete_run();
  end
endmodule
